// ---- rtl/cli_pkg.sv ----
// Shared constants for the character display instruction interpreter.
package cli_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and execution times.
  localparam int CLK_PERIOD_NS = 25;
  localparam int T_CLEAR_NS = 1530000;
  localparam int T_INSTR_NS = 39000;
  localparam int T_DATA_NS = 43000;
  localparam int CYC_CLEAR = (T_CLEAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_INSTR = (T_INSTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_DATA = (T_DATA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] LOAD_INSTR = 16'(CYC_INSTR - 1);
  localparam logic [15:0] LOAD_DATA = 16'(CYC_DATA - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Host pins, memories and address map of the text memory.
  localparam int PIN_W = 11;
  localparam logic [7:0] SPACE_CODE = 8'h20;
  localparam logic [6:0] ADDR_ZERO = 7'h00;
  localparam logic [6:0] LINE1_END = 7'h27;
  localparam logic [6:0] LINE2_START = 7'h40;
  localparam logic [6:0] LINE2_END = 7'h67;
  localparam logic [6:0] ONE_LINE_END = 7'h4f;
  localparam logic [5:0] SHIFT_LAST = 6'h27;

  ////////////////////////////////////////////////////////////////////////////
  // Row scan timing in oscillator clocks, and last row index per duty.
  localparam logic [8:0] ROW_CLKS_LONG = 9'h190;
  localparam logic [8:0] ROW_CLKS_SHORT = 9'h0c8;
  localparam logic [3:0] LAST_ROW_8 = 4'h7;
  localparam logic [3:0] LAST_ROW_11 = 4'ha;
  localparam logic [3:0] LAST_ROW_16 = 4'hf;
  localparam logic [15:0] OSC_DIV_RST = 16'h0094;

  ////////////////////////////////////////////////////////////////////////////
  // Bus register offsets and status field positions.
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_OSC_DIV = 8'h04;
  localparam int ST_AP_LSB = 0;
  localparam int ST_BUSY = 7;
  localparam int ST_GLYPH = 8;
  localparam int ST_BUS8 = 9;
  localparam int ST_TWO_LINE = 10;
  localparam int ST_FONT = 11;
  localparam int ST_DISP = 12;
  localparam int ST_CURSOR = 13;
  localparam int ST_BLINK = 14;
  localparam int ST_DIR_UP = 15;
  localparam int ST_SHIFT_EN = 16;
  localparam int ST_SHIFT_LSB = 17;
  localparam int ST_ROW_LSB = 23;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer states.
  typedef enum logic [1:0] {
    cli_st_init,
    cli_st_idle,
    cli_st_exec
  } cli_state_t;

endpackage : cli_pkg

// ---- rtl/cli_pin_sync.sv ----
// Three-stage synchroniser with agreement filter for the host pins.
module cli_pin_sync (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Raw pins and their filtered copy.
  input wire logic [cli_pkg::PIN_W-1:0] pin_i,
  output logic [cli_pkg::PIN_W-1:0] stable_o
);
  import cli_pkg::*;

  logic [PIN_W-1:0] s1_ff;
  logic [PIN_W-1:0] s2_ff;
  logic [PIN_W-1:0] s3_ff;
  logic [PIN_W-1:0] stable_ff;
  wire [PIN_W-1:0] differ = s2_ff ^ s3_ff;
  wire [PIN_W-1:0] nxt_stable = (~differ & s3_ff) | (differ & stable_ff);

  // A bit only changes once the second and third stage agree on it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      stable_ff <= '0;
    end else begin
      s1_ff <= pin_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      stable_ff <= nxt_stable;
    end
  end

  assign stable_o = stable_ff;

endmodule : cli_pin_sync

// ---- rtl/cli_core.sv ----
// Instruction decoder, host port sequencer and row scan timer.
// What this block does
// [R01] Clear fills text memory with space code, zeroes pointer, stays busy 1.53 ms.
// [R02] Return home zeroes pointer and display shift, keeps memory, busy 1.53 ms.
// [R03] Entry mode stores direction and whole-display shift enable, busy 39 us.
// [R04] Display control stores display, cursor and blink bits, busy 39 us.
// [R05] Shift moves cursor or display by direction bit, memory untouched, 39 us.
// [R06] Function set stores bus width, line count and font, busy 39 us.
// [R07] Glyph address set loads six bits and targets glyph memory, 39 us.
// [R08] Text address set loads seven bits and targets text memory, 39 us.
// [R09] Status read returns busy indicator on bit 7 and pointer below.
// [R10] Data write stores byte in last addressed memory, busy 43 us.
// [R11] Data read returns byte from last addressed memory, busy 43 us.
// [R12] Host waits half an oscillator period after not busy before next strobe.
// [R13] Eight-bit mode moves each byte in one enable transfer.
// [R14] Four-bit mode uses only the upper four data lines.
// [R15] Four-bit mode sends upper nibble first, then lower nibble.
// [R16] Four-bit mode raises busy only after the second nibble ends.
// [R17] Power-up runs initialisation with busy held high until done.
// [R18] Initialisation first writes space code into every text cell.
// [R19] Initialisation sets eight-bit bus, one line and short font.
// [R20] Initialisation clears display, cursor and blink bits.
// [R21] Initialisation sets increment direction and no display shift.
// [R22] Row lasts 400 oscillator clocks, or 200 at sixteen-row duty.
// [R23] Data access steps pointer up when direction high, else down.
// [R24] Cursor shift steps pointer; display shift leaves pointer alone.
// [R25] Two-line text addresses run 00h to 27h and 40h to 67h.
// [R26] Duty is 8 rows, 11 rows with tall font, 16 for two lines.
module cli_core #(
  parameter int CLEAR_CYC = cli_pkg::CYC_CLEAR
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Host parallel port.
  input wire logic register_select_i,
  input wire logic rw_i,
  input wire logic enable_i,
  input wire logic [7:0] db_i,
  output logic [7:0] db_o,
  output logic db_oe_o,
  // Row scan and state.
  output logic [3:0] com_row_o,
  output logic frame_start_o,
  output logic busy_indicator_o
);
  import cli_pkg::*;

  localparam logic [15:0] LOAD_CLEAR = 16'(CLEAR_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions.
  function automatic logic [6:0] cli_step(input logic [6:0] a, input logic up,
                                          input logic two, input logic glyph);
    logic [5:0] g;
    g = up ? a[5:0] + 6'h01 : a[5:0] - 6'h01;
    if (glyph) begin
      cli_step = {1'b0, g};
    end else if (two) begin
      if (up) begin
        cli_step = (a == LINE1_END) ? LINE2_START : (a == LINE2_END) ? ADDR_ZERO : a + 7'h01;
      end else begin
        cli_step = (a == ADDR_ZERO) ? LINE2_END : (a == LINE2_START) ? LINE1_END : a - 7'h01;
      end
    end else if (up) begin
      cli_step = (a == ONE_LINE_END) ? ADDR_ZERO : a + 7'h01;
    end else begin
      cli_step = (a == ADDR_ZERO) ? ONE_LINE_END : a - 7'h01;
    end
  endfunction : cli_step

  function automatic logic [5:0] cli_rot(input logic [5:0] off, input logic right);
    if (right) begin
      cli_rot = (off == SHIFT_LAST) ? 6'h00 : off + 6'h01;
    end else begin
      cli_rot = (off == 6'h00) ? SHIFT_LAST : off - 6'h01;
    end
  endfunction : cli_rot

  ////////////////////////////////////////////////////////////////////////////
  // Host pin capture and transfer framing.
  logic [PIN_W-1:0] pins_s;
  logic en_prev_ff;
  logic nib_ff;
  logic [3:0] hi_nib_ff;
  logic bus8_ff;

  cli_pin_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i({register_select_i, rw_i, enable_i, db_i}),
    .stable_o(pins_s)
  );

  wire rs_s = pins_s[10];
  wire rw_s = pins_s[9];
  wire en_s = pins_s[8];
  wire [7:0] db_s = pins_s[7:0];
  wire en_fall = en_prev_ff & ~en_s;
  wire byte_done = en_fall & (bus8_ff | nib_ff); // [R13] [R16]
  wire [7:0] in_byte = bus8_ff ? db_s : {hi_nib_ff, db_s[7:4]}; // [R14] [R15]

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_prev_ff <= 1'b0;
      nib_ff <= 1'b0;
      hi_nib_ff <= 4'h0;
    end else begin
      en_prev_ff <= en_s;
      nib_ff <= (en_fall & ~bus8_ff) ? ~nib_ff : (nib_ff & ~bus8_ff); // [R15]
      hi_nib_ff <= (en_fall & ~nib_ff) ? db_s[7:4] : hi_nib_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Instruction decode.
  cli_state_t state_ff;
  cli_state_t nxt_state;
  wire idle = (state_ff == cli_st_idle);
  // Writes and data reads that land while busy are dropped; the host polls first.
  wire cmd_take = byte_done & ~rw_s & ~rs_s & idle;
  wire dat_wr = byte_done & ~rw_s & rs_s & idle;
  wire dat_rd = byte_done & rw_s & rs_s & idle;
  wire is_text_addr = in_byte[7];
  wire is_glyph_addr = in_byte[7:6] == 2'b01;
  wire is_func = in_byte[7:5] == 3'b001;
  wire is_shift = in_byte[7:4] == 4'b0001;
  wire is_disp = in_byte[7:3] == 5'b00001;
  wire is_entry = in_byte[7:2] == 6'b000001;
  wire is_home = in_byte[7:1] == 7'b0000001;
  wire is_clear = in_byte == 8'h01;

  ////////////////////////////////////////////////////////////////////////////
  // Mode state and sequencer.
  logic [15:0] exec_ff;
  logic [7:0] clr_idx_ff;
  logic [6:0] ap_ff;
  logic glyph_sel_ff;
  logic two_line_ff;
  logic font_ff;
  logic disp_ff;
  logic cursor_ff;
  logic blink_ff;
  logic dir_up_ff;
  logic shift_en_ff;
  logic [5:0] shift_off_ff;
  logic [15:0] nxt_exec;
  logic [7:0] nxt_clr_idx;
  logic [6:0] nxt_ap;
  logic nxt_glyph_sel;
  logic nxt_bus8;
  logic nxt_two_line;
  logic nxt_font;
  logic nxt_disp;
  logic nxt_cursor;
  logic nxt_blink;
  logic nxt_dir_up;
  logic nxt_shift_en;
  logic [5:0] nxt_shift_off;
  wire clearing = ~clr_idx_ff[7];
  wire exec_done = (exec_ff == 16'h0000) & ~clearing;
  wire [6:0] ap_stepped = cli_step(ap_ff, dir_up_ff, two_line_ff, glyph_sel_ff); // [R23] [R25]

  always_comb begin
    nxt_state = state_ff;
    nxt_exec = (exec_ff != 16'h0000) ? exec_ff - 16'h0001 : exec_ff;
    nxt_clr_idx = clearing ? clr_idx_ff + 8'h01 : clr_idx_ff;
    nxt_ap = ap_ff;
    nxt_glyph_sel = glyph_sel_ff;
    nxt_bus8 = bus8_ff;
    nxt_two_line = two_line_ff;
    nxt_font = font_ff;
    nxt_disp = disp_ff;
    nxt_cursor = cursor_ff;
    nxt_blink = blink_ff;
    nxt_dir_up = dir_up_ff;
    nxt_shift_en = shift_en_ff;
    nxt_shift_off = shift_off_ff;
    case (state_ff)
      cli_st_init: begin
        if (exec_done) begin
          nxt_state = cli_st_idle; // [R17]
          nxt_bus8 = 1'b1; // [R19]
          nxt_two_line = 1'b0; // [R19]
          nxt_font = 1'b0; // [R19]
          nxt_disp = 1'b0; // [R20]
          nxt_cursor = 1'b0; // [R20]
          nxt_blink = 1'b0; // [R20]
          nxt_dir_up = 1'b1; // [R21]
          nxt_shift_en = 1'b0; // [R21]
        end
      end
      cli_st_exec: begin
        if (exec_done) begin
          nxt_state = cli_st_idle;
        end
      end
      cli_st_idle: begin
        if (cmd_take) begin
          nxt_state = cli_st_exec;
          nxt_exec = LOAD_INSTR;
          if (is_text_addr) begin
            nxt_ap = in_byte[6:0]; // [R08]
            nxt_glyph_sel = 1'b0; // [R08]
          end else if (is_glyph_addr) begin
            nxt_ap = {1'b0, in_byte[5:0]}; // [R07]
            nxt_glyph_sel = 1'b1; // [R07]
          end else if (is_func) begin
            nxt_bus8 = in_byte[4]; // [R06]
            nxt_two_line = in_byte[3]; // [R06]
            nxt_font = in_byte[2]; // [R06]
          end else if (is_shift) begin
            if (in_byte[3]) begin
              nxt_shift_off = cli_rot(shift_off_ff, in_byte[2]); // [R05] [R24]
            end else begin
              nxt_ap = cli_step(ap_ff, in_byte[2], two_line_ff, glyph_sel_ff); // [R05] [R24]
            end
          end else if (is_disp) begin
            nxt_disp = in_byte[2]; // [R04]
            nxt_cursor = in_byte[1]; // [R04]
            nxt_blink = in_byte[0]; // [R04]
          end else if (is_entry) begin
            nxt_dir_up = in_byte[1]; // [R03]
            nxt_shift_en = in_byte[0]; // [R03]
          end else if (is_home) begin
            nxt_exec = LOAD_CLEAR; // [R02]
            nxt_ap = ADDR_ZERO; // [R02]
            nxt_glyph_sel = 1'b0;
            nxt_shift_off = 6'h00; // [R02]
          end else if (is_clear) begin
            nxt_exec = LOAD_CLEAR; // [R01]
            nxt_clr_idx = 8'h00; // [R01]
            nxt_ap = ADDR_ZERO; // [R01]
            nxt_glyph_sel = 1'b0;
            nxt_shift_off = 6'h00;
            nxt_dir_up = 1'b1;
          end else begin
            nxt_state = cli_st_idle;
            nxt_exec = 16'h0000;
          end
        end else if (dat_wr) begin
          nxt_state = cli_st_exec;
          nxt_exec = LOAD_DATA; // [R10]
          nxt_ap = ap_stepped; // [R23]
          if (shift_en_ff & ~glyph_sel_ff) begin
            nxt_shift_off = cli_rot(shift_off_ff, ~dir_up_ff);
          end
        end else if (dat_rd) begin
          nxt_state = cli_st_exec;
          nxt_exec = LOAD_DATA; // [R11]
          nxt_ap = ap_stepped; // [R23]
        end
      end
      default: begin
        nxt_state = cli_st_idle;
      end
    endcase
  end

  // Reset leaves the same mode values that the power-up sequence writes.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= cli_st_init; // [R17]
      exec_ff <= LOAD_CLEAR;
      clr_idx_ff <= 8'h00; // [R18]
      ap_ff <= ADDR_ZERO;
      glyph_sel_ff <= 1'b0;
      bus8_ff <= 1'b1;
      two_line_ff <= 1'b0;
      font_ff <= 1'b0;
      disp_ff <= 1'b0;
      cursor_ff <= 1'b0;
      blink_ff <= 1'b0;
      dir_up_ff <= 1'b1;
      shift_en_ff <= 1'b0;
      shift_off_ff <= 6'h00;
    end else begin
      state_ff <= nxt_state;
      exec_ff <= nxt_exec;
      clr_idx_ff <= nxt_clr_idx;
      ap_ff <= nxt_ap;
      glyph_sel_ff <= nxt_glyph_sel;
      bus8_ff <= nxt_bus8;
      two_line_ff <= nxt_two_line;
      font_ff <= nxt_font;
      disp_ff <= nxt_disp;
      cursor_ff <= nxt_cursor;
      blink_ff <= nxt_blink;
      dir_up_ff <= nxt_dir_up;
      shift_en_ff <= nxt_shift_en;
      shift_off_ff <= nxt_shift_off;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Text and glyph memories.
  logic [7:0] text_mem [0:127];
  logic [7:0] glyph_mem [0:63];
  logic [7:0] rd_ff;
  wire text_we = clearing | (dat_wr & ~glyph_sel_ff); // [R01] [R18] [R10]
  wire [6:0] text_wa = clearing ? clr_idx_ff[6:0] : ap_ff;
  wire [7:0] text_wd = clearing ? SPACE_CODE : in_byte;
  wire glyph_we = dat_wr & glyph_sel_ff; // [R10]

  // The read latch follows the pointer while idle, so a read strobe sees a settled byte.
  always_ff @(posedge clk_i) begin
    if (text_we) begin
      text_mem[text_wa] <= text_wd;
    end
    if (glyph_we) begin
      glyph_mem[ap_ff[5:0]] <= in_byte;
    end
    if (idle) begin
      rd_ff <= glyph_sel_ff ? glyph_mem[ap_ff[5:0]] : text_mem[ap_ff]; // [R11]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host read path.
  logic [7:0] db_o_ff;
  wire busy = ~idle;
  wire [7:0] rd_byte = rs_s ? rd_ff : {busy, ap_ff}; // [R09] [R11]
  wire [7:0] nxt_db_o = bus8_ff ? rd_byte :
                        (nib_ff ? {rd_byte[3:0], 4'h0} : {rd_byte[7:4], 4'h0}); // [R14] [R15]

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      db_o_ff <= 8'h00;
    end else begin
      db_o_ff <= nxt_db_o;
    end
  end

  assign db_o = db_o_ff;
  assign db_oe_o = en_s & rw_s;
  assign busy_indicator_o = busy; // [R16] [R17]

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator tick and row scan.
  logic [15:0] osc_div_ff;
  logic [15:0] osc_cnt_ff;
  logic [8:0] row_cnt_ff;
  logic [3:0] com_row_ff;
  logic frame_ff;
  wire osc_tick = (osc_div_ff <= 16'h0001) | (osc_cnt_ff >= osc_div_ff - 16'h0001);
  wire [8:0] row_len = two_line_ff ? ROW_CLKS_SHORT : ROW_CLKS_LONG; // [R22]
  wire [3:0] last_row = two_line_ff ? LAST_ROW_16 : (font_ff ? LAST_ROW_11 : LAST_ROW_8); // [R26]
  wire row_end = osc_tick & (row_cnt_ff >= row_len - 9'h001);
  wire frame_end = row_end & (com_row_ff >= last_row); // [R22]

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_cnt_ff <= 16'h0000;
      row_cnt_ff <= 9'h000;
      com_row_ff <= 4'h0;
      frame_ff <= 1'b0;
    end else begin
      osc_cnt_ff <= osc_tick ? 16'h0000 : osc_cnt_ff + 16'h0001;
      row_cnt_ff <= row_end ? 9'h000 : (osc_tick ? row_cnt_ff + 9'h001 : row_cnt_ff);
      com_row_ff <= frame_end ? 4'h0 : (row_end ? com_row_ff + 4'h1 : com_row_ff);
      frame_ff <= frame_end;
    end
  end

  assign com_row_o = com_row_ff;
  assign frame_start_o = frame_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone register slave.
  logic ack_ff;
  logic [31:0] wb_dat_ff;
  logic [31:0] status_w;
  logic [31:0] rd_mux;
  wire req = wb_cyc_i & wb_stb_i & ~ack_ff;
  wire hit_status = wb_adr_i[7:2] == ADDR_STATUS[7:2];
  wire hit_osc = wb_adr_i[7:2] == ADDR_OSC_DIV[7:2];
  wire osc_wr = req & wb_we_i & hit_osc;

  always_comb begin
    status_w = 32'h0000_0000;
    status_w[ST_AP_LSB +: 7] = ap_ff;
    status_w[ST_BUSY] = busy;
    status_w[ST_GLYPH] = glyph_sel_ff;
    status_w[ST_BUS8] = bus8_ff;
    status_w[ST_TWO_LINE] = two_line_ff;
    status_w[ST_FONT] = font_ff;
    status_w[ST_DISP] = disp_ff;
    status_w[ST_CURSOR] = cursor_ff;
    status_w[ST_BLINK] = blink_ff;
    status_w[ST_DIR_UP] = dir_up_ff;
    status_w[ST_SHIFT_EN] = shift_en_ff;
    status_w[ST_SHIFT_LSB +: 6] = shift_off_ff;
    status_w[ST_ROW_LSB +: 4] = com_row_ff;
    rd_mux = 32'h0000_0000;
    if (hit_status) begin
      rd_mux = status_w;
    end else if (hit_osc) begin
      rd_mux = {16'h0000, osc_div_ff};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      wb_dat_ff <= 32'h0000_0000;
      osc_div_ff <= OSC_DIV_RST;
    end else begin
      ack_ff <= req;
      wb_dat_ff <= req ? rd_mux : wb_dat_ff;
      osc_div_ff[7:0] <= (osc_wr & wb_sel_i[0]) ? wb_dat_i[7:0] : osc_div_ff[7:0];
      osc_div_ff[15:8] <= (osc_wr & wb_sel_i[1]) ? wb_dat_i[15:8] : osc_div_ff[15:8];
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = wb_dat_ff;

endmodule : cli_core

// ---- tb/cli_core_assertions.sv ----
// Port-level checks on the instruction interpreter.
module cli_core_assertions #(
  parameter int CLEAR_CYC = cli_pkg::CYC_CLEAR
) (
  // Clock, reset and bus.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Host port.
  input wire logic register_select_i,
  input wire logic rw_i,
  input wire logic enable_i,
  input wire logic [7:0] db_i,
  input wire logic [7:0] db_o,
  input wire logic db_oe_o,
  // Scan and state.
  input wire logic [3:0] com_row_o,
  input wire logic frame_start_o,
  input wire logic busy_indicator_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import cli_pkg::*;
  logic [31:0] busy_cnt_ff;
  logic [31:0] nxt_busy_cnt;
  assign nxt_busy_cnt = busy_indicator_o ? busy_cnt_ff + 32'h1 : 32'h0;
  always_ff @(posedge clk_i) begin
    busy_cnt_ff <= rst_i ? 32'h0 : nxt_busy_cnt;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////
  ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack longer than one cycle");
  oe_write_a: assert property ((!rw_i) [*6] |-> !db_oe_o)
    else $error("data bus driven during a write");
  oe_strobe_a: assert property ((!enable_i) [*6] |-> !db_oe_o)
    else $error("data bus driven without strobe");
  init_busy_a: assert property ($fell(rst_i) |-> busy_indicator_o [*8])
    else $error("busy low during start-up");
  busy_len_a: assert property ($fell(busy_indicator_o) |->
    busy_cnt_ff inside {CLEAR_CYC, CYC_INSTR, CYC_DATA})
    else $error("busy period of wrong length");
  busy_cause_a: assert property ($rose(busy_indicator_o) |-> !enable_i)
    else $error("busy rose while strobe high");
  row_step_a: assert property ($changed(com_row_o) && com_row_o != 4'h0 |->
    com_row_o == $past(com_row_o) + 4'h1)
    else $error("row index skipped");
  cover property ($fell(busy_indicator_o));
  cover property (frame_start_o);
  cover property (db_oe_o && register_select_i);
endmodule : cli_core_assertions

bind cli_core cli_core_assertions #(.CLEAR_CYC(CLEAR_CYC)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .register_select_i(register_select_i), .rw_i(rw_i),
  .enable_i(enable_i), .db_i(db_i), .db_o(db_o), .db_oe_o(db_oe_o), .com_row_o(com_row_o),
  .frame_start_o(frame_start_o), .busy_indicator_o(busy_indicator_o));

// ---- tb/cli_host_model.sv ----
// Host processor model for the parallel port.
module cli_host_model (
  // Clock.
  input wire logic clk_i,
  // Port towards the interpreter.
  input wire logic [7:0] db_i,
  output logic register_select_o,
  output logic rw_o,
  output logic enable_o,
  output logic [7:0] db_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic four_bit = 1'b0;
  initial begin
    register_select_o = 1'b0;
    rw_o = 1'b0;
    enable_o = 1'b0;
    db_o = 8'h00;
  end
  // Strobe held six cycles each way so the pin filter sees both levels.
  task automatic pulse(input logic rs, input logic rw, input logic [7:0] v,
                       output logic [7:0] rd);
    @(posedge clk_i);
    register_select_o <= rs;
    rw_o <= rw;
    db_o <= rw ? ~db_o : v;
    enable_o <= 1'b1;
    repeat (6) @(posedge clk_i);
    rd = db_i;
    enable_o <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask : pulse
  task automatic xfer(input logic rs, input logic rw, input logic [7:0] v,
                      output logic [7:0] rd);
    logic [7:0] hi;
    logic [7:0] lo;
    if (four_bit) begin
      pulse(rs, rw, {v[7:4], ~v[7:4]}, hi);
      pulse(rs, rw, {v[3:0], ~v[3:0]}, lo);
      rd = {hi[7:4], lo[7:4]};
    end else begin
      pulse(rs, rw, v, rd);
    end
  endtask : xfer
endmodule : cli_host_model

// ---- tb/tb_top.sv ----
// Self-checking bench for the character display instruction interpreter.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import cli_pkg::*;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, rs, rw, en, db_oe, fs, busy;
  logic [7:0] wb_adr_i, db_h, db_d, d;
  logic [3:0] wb_sel_i, row;
  logic [31:0] wb_dat_i, wb_dat_o, w;
  int miscompares = 0;
  int comparisons = 0;
  cli_core #(.CLEAR_CYC(200)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .register_select_i(rs), .rw_i(rw), .enable_i(en), .db_i(db_h),
    .db_o(db_d), .db_oe_o(db_oe), .com_row_o(row), .frame_start_o(fs), .busy_indicator_o(busy));
  // A data bus that is not driven reads back inverted, so a missing enable shows up.
  cli_host_model host (.clk_i(clk_i), .db_i(db_oe ? db_d : ~db_d), .register_select_o(rs),
    .rw_o(rw), .enable_o(en), .db_o(db_h));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  ////////////////////////////////////////
  task automatic results();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic stall(input string what);
    check(what, 32'h1, 32'h0);
    results();
  endtask : stall
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] wd,
                    output logic [31:0] rd);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= wd;
    for (int i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1) break;
    end
    if (wb_ack_o !== 1'b1) stall("wb_ack");
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task automatic reg_chk(input logic [31:0] mask, input logic [31:0] e);
    wb(1'b0, ADDR_STATUS, 32'h0, w);
    check("status_reg", w & mask, e);
  endtask : reg_chk
  // Polling costs a status read each time; the only fixed wait is OSC_DIV_RST[15:1] cycles once not busy.
  task automatic ready();
    logic [7:0] s;
    for (int i = 0; i < 400; i++) begin
      host.xfer(1'b0, 1'b1, 8'h00, s);
      if (s[7] === 1'b0) begin
        repeat (OSC_DIV_RST[15:1]) @(posedge clk_i);
        return;
      end
    end
    stall("busy_timeout");
  endtask : ready
  task automatic op(input logic r, input logic q, input logic [7:0] v);
    ready();
    host.xfer(r, q, v, d);
  endtask : op
  task automatic ptr_chk(input logic [7:0] e);
    op(1'b0, 1'b1, 8'h00);
    check("status_byte", 32'(d), 32'(e));
  endtask : ptr_chk
  task automatic rd_chk(input logic [7:0] e);
    op(1'b1, 1'b1, 8'h00);
    check("read_data", 32'(d), 32'(e));
  endtask : rd_chk
  task automatic frame_chk(input logic [31:0] e);
    logic [31:0] n;
    repeat (2) begin
      n = 0;
      do begin
        @(posedge clk_i);
        #1;
        n++;
      end while (fs !== 1'b1 && n < 32'd6000);
    end
    check("frame_len", n, e);
    check("com_row", 32'(row), 32'h0);
  endtask : frame_chk
  ////////////////////////////////////////
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, rst_i} = 4'h1;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    ptr_chk(8'h00);
    reg_chk(32'h007fffff, 32'h00008200);
    wb(1'b0, ADDR_OSC_DIV, 32'h0, w);
    check("osc_div_reset", w, 32'(OSC_DIV_RST));
    wb(1'b1, ADDR_OSC_DIV, 32'h1, w);
    wb(1'b0, ADDR_OSC_DIV, 32'h0, w);
    check("osc_div", w, 32'h1);
    wb(1'b0, 8'h08, 32'h0, w);
    check("unmapped", w, 32'h0);
    frame_chk(32'd3200);
    op(1'b0, 1'b0, 8'hff);
    rd_chk(SPACE_CODE);
    op(1'b0, 1'b0, 8'h85);
    op(1'b1, 1'b0, 8'h41);
    op(1'b1, 1'b0, 8'h42);
    ptr_chk(8'h07);
    op(1'b0, 1'b0, 8'h85);
    rd_chk(8'h41);
    rd_chk(8'h42);
    op(1'b0, 1'b0, 8'h04);
    op(1'b0, 1'b0, 8'h90);
    op(1'b1, 1'b0, 8'h33);
    ptr_chk(8'h0f);
    op(1'b0, 1'b0, 8'h14);
    ptr_chk(8'h10);
    op(1'b0, 1'b0, 8'h10);
    ptr_chk(8'h0f);
    op(1'b0, 1'b0, 8'h1c);
    ptr_chk(8'h0f);
    reg_chk(32'h007e0000, 32'h00020000);
    op(1'b0, 1'b0, 8'h02);
    ptr_chk(8'h00);
    reg_chk(32'h007e0000, 32'h0);
    op(1'b0, 1'b0, 8'h85);
    rd_chk(8'h41);
    op(1'b0, 1'b0, 8'h0f);
    reg_chk(32'h00007000, 32'h00007000);
    op(1'b0, 1'b0, 8'h07);
    reg_chk(32'h00018000, 32'h00018000);
    op(1'b1, 1'b0, 8'h61);
    reg_chk(32'h007e0000, 32'h004e0000);
    op(1'b0, 1'b0, 8'h06);
    op(1'b0, 1'b0, 8'h43);
    ptr_chk(8'h03);
    reg_chk(32'h00000100, 32'h00000100);
    op(1'b1, 1'b0, 8'h55);
    op(1'b0, 1'b0, 8'h43);
    rd_chk(8'h55);
    op(1'b0, 1'b0, 8'hc3);
    ptr_chk(8'h43);
    reg_chk(32'h00000100, 32'h0);
    op(1'b0, 1'b0, 8'h38);
    reg_chk(32'h00000400, 32'h00000400);
    frame_chk(32'd3200);
    op(1'b0, 1'b0, 8'h34);
    frame_chk(32'd4400);
    op(1'b0, 1'b0, 8'h30);
    op(1'b0, 1'b0, 8'h01);
    ptr_chk(8'h00);
    op(1'b0, 1'b0, 8'hc3);
    rd_chk(SPACE_CODE);
    op(1'b0, 1'b0, 8'h20);
    host.four_bit = 1'b1;
    op(1'b0, 1'b0, 8'h85);
    ready();
    host.pulse(1'b1, 1'b0, 8'h5a, d);
    repeat (8) @(posedge clk_i);
    #1;
    check("busy_half", 32'(busy), 32'h0);
    host.pulse(1'b1, 1'b0, 8'ha5, d);
    ptr_chk(8'h06);
    op(1'b0, 1'b0, 8'h85);
    rd_chk(8'h5a);
    op(1'b0, 1'b0, 8'h30);
    host.four_bit = 1'b0;
    ptr_chk(8'h06);
    results();
  end
endmodule : tb_top
